/* vpw_consts.svh */
/*
 Constants of the VPW transmit opcode sequencer: register indices,
 field positions, frame limits, CRC and symbol timing.
 Assumes inclusion by bare name from the checker, the top module and the bench.
*/
`ifndef VPW_CONSTS_SVH
`define VPW_CONSTS_SVH
// ==================================================
// Register indices (byte address is four times)
`define VPW_IDX_TRANSMIT_BYTE_REG 10'h0F1
`define VPW_IDX_TRANSMIT_OPCODE   10'h0F3
`define VPW_IDX_CTRL   10'h0F5
`define VPW_IDX_STAT   10'h0F6
`define VPW_IDX_PADDR  10'h0F7
// ==================================================
// Fields and reset values
`define VPW_OPREG_RST  8'h00
`define VPW_OPREG_MASK 8'hF7
`define VPW_CTRL_EN    0
`define VPW_CTRL_NFL   1
`define VPW_ST_TRA     1
`define VPW_ST_TRANSMIT_UNDERFLOW_FLAG    2
`define VPW_ST_CRC_ERROR_FLAG    3
// ==================================================
// Frame limits
`define VPW_MLC_MAX    4'hB
`define VPW_CNT_MSG    4'hA
`define VPW_CNT_RESPONSE_TYPE1_OP   4'hB
`define VPW_CNT_RESPONSE_TYPE3_OP   4'h9
`define VPW_CNT_IFR3C  4'hA
// ==================================================
// CRC and timing
`define VPW_CRC_INIT   8'hFF
`define VPW_CRC_POLY   8'h1D
`define VPW_CLK_MHZ    250
`define VPW_BRK_US     300
`define VPW_SOF_US     200
`define VPW_SHORT_US   64
`define VPW_LONG_US    128
`define VPW_EOD_US     200
`endif

/* vpw_node_model.sv */
/*
 Other nodes on the VPW bus, as the receive path reports them.
 Assumes body_end is called just after a rising edge.
*/
`timescale 1ns/1ns
module vpw_node_model #(
    parameter int IDLE_GAP = 30
) (
    input  wire logic  clk,
    input  wire logic  busOutputPin,
    output logic       busIdle,
    output logic [3:0] rxByteCount,
    output logic       eodMinPulse,
    output logic       rxCrcOk,
    output logic       frameErr,
    output logic       bitErr,
    output logic       breakErr,
    output logic       rxIfrPortion,
    output logic       arbLost
);
    int   quiet = 0;
    logic inBody = 1'b0;
    initial begin
        {busIdle, rxByteCount, eodMinPulse, rxCrcOk} = 7'h0;
        {frameErr, bitErr, breakErr, rxIfrPortion, arbLost} = 5'h0;
    end
    // ==========
    // Idle needs a gap longer than any symbol or EOD
    always @(posedge clk) begin
        quiet   <= (busOutputPin || inBody) ? 0 : quiet + 1;
        busIdle <= !busOutputPin && !inBody && quiet >= IDLE_GAP;
    end
    // ==========
    // One received body of n bytes closed by a minimum EOD
    task automatic body_end(input logic [3:0] n, input logic ok);
        inBody      <= 1'b1;
        rxByteCount <= n;
        rxCrcOk     <= ok;
        repeat (20) @(posedge clk);
        eodMinPulse <= 1'b1;
        @(posedge clk);
        eodMinPulse <= 1'b0;
        inBody      <= 1'b0;
    endtask
endmodule

/* vpw_pkg.sv */
/*
 Types of the VPW transmit opcode sequencer.
 Assumes nothing beyond the constants header.
*/
package vpw_pkg;
    // ==================================================
    // Types
    typedef enum logic [2:0] {
        VPW_IDLE = 3'b000,
        VPW_SOF  = 3'b001,
        VPW_DATA = 3'b010,
        VPW_EOD  = 3'b011,
        VPW_BRK  = 3'b100
    } vpw_state_t;
    typedef enum logic [2:0] {
        OP_CANCEL = 3'b000,
        OP_BRK    = 3'b001,
        OP_MSG    = 3'b010,
        OP_MSGC   = 3'b011,
        OP_RESPONSE_TYPE1_OP   = 3'b100,
        OP_RESPONSE_TYPE2_OP   = 3'b101,
        OP_RESPONSE_TYPE3_OP   = 3'b110,
        OP_IFR3C  = 3'b111
    } vpw_op_t;
endpackage

/* vpw_seq_chk.sv */
/*
 Port checker of the VPW transmit opcode sequencer.
 Assumes binding to vpw_tx_opcode_seq in a bench with short symbol counts.
*/
`timescale 1ns/1ns
`include "vpw_consts.svh"
module vpw_seq_chk #(
    parameter logic [16:0] BRK_CYC = 17'h14,
    parameter logic [16:0] SOF_CYC = 17'h0A
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  rxByteCount,
    input wire logic        busOutputPin
);
    // ==========
    // Data phase tracking
    logic       dpVld, dpWr, dpUnm, ctrlEn, ctrlNfl;
    logic [9:0] dpIdx;
    logic [7:0] quiet, hiCnt;
    wire        wrOp = dpVld && dpWr && !dpUnm && dpIdx == `VPW_IDX_TRANSMIT_OPCODE;
    wire        rdOp = dpVld && !dpWr && !dpUnm && dpIdx == `VPW_IDX_TRANSMIT_OPCODE;
    wire        wrCtl = dpVld && dpWr && !dpUnm && dpIdx == `VPW_IDX_CTRL;
    // Longer than any symbol plus EOD, so the sequencer must be idle
    wire        calm = quiet > 8'h1C && !busOutputPin;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {dpVld, dpWr, dpUnm, ctrlEn, ctrlNfl} <= 5'h0;
            dpIdx <= 10'h0;
            quiet <= 8'h0;
            hiCnt <= 8'h0;
        end else begin
            dpVld <= hsel && htrans[1] && hready;
            dpWr  <= hwrite;
            dpUnm <= |haddr[31:12];
            dpIdx <= haddr[11:2];
            if (wrCtl) begin
                ctrlEn  <= hwdata[`VPW_CTRL_EN];
                ctrlNfl <= hwdata[`VPW_CTRL_NFL];
            end
            quiet <= busOutputPin ? 8'h0 : quiet + {7'h0, quiet != 8'hFF};
            hiCnt <= busOutputPin ? hiCnt + 8'h1 : 8'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Properties
    a_slave_ready: assert property (hreadyout && !hresp)
        else $error("slave stalled or not OKAY");
    a_reserved_zero: assert property (rdOp |-> hrdata[3] == 1'b0 && hrdata[31:8] == 24'h0)
        else $error("opcode read shows reserved bits");
    a_unmapped_zero: assert property (dpVld && !dpWr && dpUnm |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_length_abort: assert property (wrOp && ctrlEn && !ctrlNfl && hwdata[2] &&
        hwdata[7:4] > 4'hB && calm |=> !busOutputPin [*8])
        else $error("bad length count transmitted");
    a_ifr_waits: assert property (wrOp && ctrlEn && hwdata[2] && calm |=> !busOutputPin [*4])
        else $error("response sent before EOD");
    a_msg_sof: assert property (wrOp && ctrlEn && hwdata[2:1] == 2'b01 && rxByteCount < 4'hA
        && calm |-> ##[1:3] busOutputPin [*8])
        else $error("no SOF after message opcode");
    a_break_now: assert property (wrOp && ctrlEn && hwdata[2:0] == 3'b001
        |-> ##[1:2] busOutputPin [*8])
        else $error("break not driven at once");
    a_active_bound: assert property (hiCnt <= 8'(BRK_CYC + SOF_CYC))
        else $error("active level held too long");
    c_break: cover property (wrOp && hwdata[2:0] == 3'b001);
    c_frame: cover property (wrOp && hwdata[2:0] == 3'b011 && calm);
    c_unmapped: cover property (dpVld && dpUnm);
endmodule

/* vpw_tx_opcode_seq.sv */
/*
 Transmit opcode sequencer of a VPW serial bus controller, AHB-Lite slave.
 Assumes a receive path outside that supplies byte count, EOD, CRC and
 error status, bus idle and arbitration loss, all synchronous to clk.
*/
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "vpw_consts.svh"
module vpw_tx_opcode_seq #(
    parameter logic [16:0] BRK_CYC   = 17'(`VPW_BRK_US * `VPW_CLK_MHZ),
    parameter logic [16:0] SOF_CYC   = 17'(`VPW_SOF_US * `VPW_CLK_MHZ),
    parameter logic [16:0] SHORT_CYC = 17'(`VPW_SHORT_US * `VPW_CLK_MHZ),
    parameter logic [16:0] LONG_CYC  = 17'(`VPW_LONG_US * `VPW_CLK_MHZ),
    parameter logic [16:0] EOD_CYC   = 17'(`VPW_EOD_US * `VPW_CLK_MHZ)
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        busIdle,
    input  wire logic [3:0]  rxByteCount,
    input  wire logic        eodMinPulse,
    input  wire logic        rxCrcOk,
    input  wire logic        frameErr,
    input  wire logic        bitErr,
    input  wire logic        breakErr,
    input  wire logic        rxIfrPortion,
    input  wire logic        arbLost,
    output logic             busOutputPin
);
    import vpw_pkg::*;

    // ==================================================
    // Reset release
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ==================================================
    // Bus slave
    logic        wrPend;
    logic [9:0]  wrIdx;
    logic [7:0]  transmit_byte_reg;
    logic [7:0]  opReg;
    logic [7:0]  paddr;
    logic        blockEnable;
    logic        frameLimitOff;
    logic        trdyFlag;
    logic        traFlag;
    logic        tdufFlag;
    logic        crceFlag;
    vpw_state_t  state;
    wire         addrOk = hsel & htrans[1] & hready & (haddr[31:12] == 20'h0);
    wire  [9:0]  aIdx   = haddr[11:2];
    // Unmapped reads still load hrdata, so they return zero and not stale data
    wire         rdSel  = hsel & htrans[1] & hready & !hwrite;
    wire         busy   = (state != VPW_IDLE);
    wire  [7:0]  statusVec = {3'h0, busy, crceFlag, tdufFlag, traFlag, trdyFlag};
    wire  [7:0]  rdMux =
        (aIdx == `VPW_IDX_TRANSMIT_BYTE_REG) ? transmit_byte_reg :
        (aIdx == `VPW_IDX_TRANSMIT_OPCODE)   ? (opReg & `VPW_OPREG_MASK) :
        (aIdx == `VPW_IDX_CTRL)   ? {6'h0, frameLimitOff, blockEnable} :
        (aIdx == `VPW_IDX_STAT)   ? statusVec :
        (aIdx == `VPW_IDX_PADDR)  ? paddr : 8'h00;
    wire opWr   = wrPend & (wrIdx == `VPW_IDX_TRANSMIT_OPCODE);
    wire dataWr = wrPend & (wrIdx == `VPW_IDX_TRANSMIT_BYTE_REG);
    wire ctrlWr = wrPend & (wrIdx == `VPW_IDX_CTRL);
    wire statWr = wrPend & (wrIdx == `VPW_IDX_STAT);
    wire adrWr  = wrPend & (wrIdx == `VPW_IDX_PADDR);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            wrPend <= 1'b0;
            wrIdx  <= 10'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend <= addrOk & hwrite;
            wrIdx  <= aIdx;
            if (rdSel) begin
                hrdata <= addrOk ? {24'h00_0000, rdMux} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            transmit_byte_reg        <= 8'h00;
            opReg         <= `VPW_OPREG_RST;
            paddr         <= 8'h00;
            blockEnable   <= 1'b0;
            frameLimitOff <= 1'b0;
        end else begin
            if (dataWr) begin
                transmit_byte_reg <= hwdata[7:0];
            end
            if (opWr) begin
                opReg <= hwdata[7:0] & `VPW_OPREG_MASK;
            end
            if (adrWr) begin
                paddr <= hwdata[7:0];
            end
            if (ctrlWr) begin
                blockEnable   <= hwdata[`VPW_CTRL_EN];
                frameLimitOff <= hwdata[`VPW_CTRL_NFL];
            end
        end
    end

    // ==================================================
    // Opcode decode and checks
    logic        pendValid;
    vpw_op_t     pendOp;
    logic [3:0]  pendMlc;
    vpw_op_t     execOp;
    logic [16:0] cnt;
    logic [7:0]  shift;
    logic [2:0]  bitIdx;
    logic        lvl;
    logic [7:0]  crc;
    logic        crcNext;
    logic        invCrc;
    logic        isCrc;
    wire vpw_op_t wOp  = vpw_op_t'(hwdata[2:0]);
    wire [3:0]    wMlc = hwdata[7:4];
    wire isMsg    = (wOp == OP_MSG) | (wOp == OP_MSGC);
    wire isIfr    = hwdata[2];
    wire txActive = (state == VPW_SOF) | (state == VPW_DATA);
    wire exMsg    = txActive & (execOp == OP_MSG);
    wire exIfr3   = txActive & (execOp == OP_RESPONSE_TYPE3_OP);
    wire exFinal  = txActive & ((execOp == OP_RESPONSE_TYPE1_OP) | (execOp == OP_RESPONSE_TYPE2_OP)
                    | (execOp == OP_IFR3C));
    wire nflOn    = !frameLimitOff;
    // Length count only matters for responses
    wire mlcBad   = isIfr & nflOn & (wMlc > `VPW_MLC_MAX);
    wire msgOver  = isMsg & (exIfr3 | (nflOn & (
                    ((wOp == OP_MSG) & (rxByteCount == `VPW_CNT_MSG)) |
                    ((wOp == OP_MSGC) & (rxByteCount > `VPW_CNT_MSG)))));
    wire ifrLim   = isIfr & nflOn & (
                    (((wOp == OP_RESPONSE_TYPE1_OP) | (wOp == OP_RESPONSE_TYPE2_OP))
                        & (rxByteCount > `VPW_CNT_RESPONSE_TYPE1_OP)) |
                    ((wOp == OP_RESPONSE_TYPE3_OP) & (rxByteCount > `VPW_CNT_RESPONSE_TYPE3_OP)) |
                    ((wOp == OP_IFR3C) & (rxByteCount > `VPW_CNT_IFR3C)));
    wire ifrOver  = isIfr & (exMsg | (exIfr3 & !wOp[1]) | (exIfr3 & ifrLim));
    wire ifrBusy  = isIfr & (exFinal | (rxIfrPortion & !exIfr3));
    wire ufWr     = opWr & (msgOver | ifrOver);
    wire rejWr    = opWr & (ufWr | mlcBad | ifrLim | ifrBusy);
    wire acceptWr = opWr & (isMsg | isIfr) & !rejWr & blockEnable;
    wire cancelWr = opWr & (wOp == OP_CANCEL);
    wire brkWr    = opWr & (wOp == OP_BRK) & blockEnable;

    // ==================================================
    // Response gating at end of body
    wire ifrEod   = (state == VPW_IDLE) & pendValid & pendOp[2] & eodMinPulse;
    wire rxErr    = frameErr | bitErr | breakErr;
    wire mlcMiss  = !rxErr & rxCrcOk & (pendMlc != 4'h0)
                    & (pendMlc != rxByteCount);
    wire ifrStart = ifrEod & !rxErr & rxCrcOk & !mlcMiss;
    wire ifrDrop  = ifrEod & !ifrStart;
    wire arbDrop  = arbLost & txActive;
    wire msgStart = (state == VPW_IDLE) & pendValid & !pendOp[2] & busIdle;

    // ==================================================
    // Byte sequencing
    wire symEnd   = (cnt == 17'h0_0000);
    wire byteEnd  = symEnd & (state == VPW_DATA) & (bitIdx == 3'h7);
    wire contOk   = pendValid & (
                    (!pendOp[2] & (execOp == OP_MSG)) |
                    ((pendOp == OP_RESPONSE_TYPE3_OP) | (pendOp == OP_IFR3C)) & (execOp == OP_RESPONSE_TYPE3_OP));
    wire starve   = (execOp == OP_MSG) | (execOp == OP_RESPONSE_TYPE3_OP);
    wire sofEnd   = (state == VPW_SOF) & symEnd;
    wire loadNow  = ifrStart | sofEnd | (byteEnd & !isCrc & !crcNext & contOk);
    wire uflowNow = byteEnd & !isCrc & !crcNext & !contOk & starve;
    wire crcLoad  = byteEnd & !isCrc & (crcNext | uflowNow);
    wire eodNow   = byteEnd & !loadNow & !crcLoad;
    wire fresh    = (state != VPW_DATA);
    // Byte is read at load time, so a DMA data write after the opcode is still sent
    wire [7:0] loadByte = (pendOp == OP_RESPONSE_TYPE1_OP) | (pendOp == OP_RESPONSE_TYPE2_OP)
                        ? paddr : transmit_byte_reg;
    wire       loadLvl  = fresh ? !sofEnd : !lvl;
    wire [7:0] crcBase  = fresh ? `VPW_CRC_INIT : crc;
    wire [7:0] crcOut   = (invCrc | uflowNow) ? crc : ~crc;

    function automatic logic [16:0] symLen(input logic b, input logic l);
        symLen = ((b ^ l) ? LONG_CYC : SHORT_CYC) - 17'h0_0001;
    endfunction

    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? `VPW_CRC_POLY : 8'h00);
        end
        crcStep = r;
    endfunction

    // ==================================================
    // Pending opcode
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            pendValid <= 1'b0;
            pendOp    <= OP_CANCEL;
            pendMlc   <= 4'h0;
        end else if (!blockEnable | brkWr | cancelWr | ufWr) begin
            pendValid <= 1'b0;
        end else if (acceptWr) begin
            pendValid <= 1'b1;
            pendOp    <= wOp;
            pendMlc   <= wMlc;
        end else if (loadNow | ifrDrop | arbDrop) begin
            pendValid <= 1'b0;
        end
    end

    // ==================================================
    // Flags; a set in the same cycle beats a software clear
    wire traSet  = rejWr | (ifrDrop & mlcMiss);
    wire tdufSet = ufWr | uflowNow;
    wire crceSet = ifrEod & !rxErr & !rxCrcOk;
    wire trdySet = !blockEnable | cancelWr | brkWr | traSet | loadNow
                   | ifrDrop | arbDrop;
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            trdyFlag <= 1'b1;
            traFlag  <= 1'b0;
            tdufFlag <= 1'b0;
            crceFlag <= 1'b0;
        end else begin
            trdyFlag <= trdySet | (trdyFlag & !opWr);
            traFlag  <= traSet | (traFlag & !(statWr & !hwdata[`VPW_ST_TRA]));
            tdufFlag <= tdufSet | (tdufFlag & !(statWr & !hwdata[`VPW_ST_TRANSMIT_UNDERFLOW_FLAG]));
            crceFlag <= crceSet | (crceFlag & !(statWr & !hwdata[`VPW_ST_CRC_ERROR_FLAG]));
        end
    end

    // ==================================================
    // Symbol engine
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state   <= VPW_IDLE;
            cnt     <= 17'h0_0000;
            shift   <= 8'h00;
            bitIdx  <= 3'h0;
            lvl     <= 1'b0;
            crc     <= `VPW_CRC_INIT;
            execOp  <= OP_CANCEL;
            crcNext <= 1'b0;
            invCrc  <= 1'b0;
            isCrc   <= 1'b0;
        end else if (!blockEnable) begin
            state   <= VPW_IDLE;
            crcNext <= 1'b0;
            invCrc  <= 1'b0;
        end else if (brkWr) begin
            state <= VPW_BRK;
            cnt   <= BRK_CYC - 17'h0_0001;
        end else if (arbDrop) begin
            state <= VPW_IDLE;
        end else if (loadNow) begin
            state   <= VPW_DATA;
            shift   <= loadByte;
            bitIdx  <= 3'h0;
            lvl     <= loadLvl;
            cnt     <= symLen(loadByte[7], loadLvl);
            crc     <= crcStep(crcBase, loadByte);
            execOp  <= pendOp;
            crcNext <= pendOp[1] & pendOp[0];
            invCrc  <= 1'b0;
            isCrc   <= 1'b0;
        end else if (crcLoad) begin
            shift   <= crcOut;
            bitIdx  <= 3'h0;
            lvl     <= !lvl;
            cnt     <= symLen(crcOut[7], !lvl);
            crcNext <= 1'b0;
            isCrc   <= 1'b1;
        end else if (eodNow) begin
            state <= VPW_EOD;
            lvl   <= 1'b0;
            cnt   <= EOD_CYC - 17'h0_0001;
        end else begin
            if (ufWr) begin
                crcNext <= 1'b1;
                invCrc  <= 1'b1;
            end
            unique case (state)
                VPW_IDLE: begin
                    if (msgStart) begin
                        state <= VPW_SOF;
                        cnt   <= SOF_CYC - 17'h0_0001;
                    end
                end
                VPW_DATA: begin
                    if (!symEnd) begin
                        cnt <= cnt - 17'h0_0001;
                    end else begin
                        shift  <= {shift[6:0], 1'b0};
                        bitIdx <= bitIdx + 3'h1;
                        lvl    <= !lvl;
                        cnt    <= symLen(shift[6], !lvl);
                    end
                end
                VPW_SOF, VPW_EOD, VPW_BRK: begin
                    if (!symEnd) begin
                        cnt <= cnt - 17'h0_0001;
                    end else begin
                        state <= VPW_IDLE;
                    end
                end
                default: state <= VPW_IDLE;
            endcase
        end
    end

    // Active level on the bus during SOF, break and active data symbols
    assign busOutputPin = (state == VPW_SOF) | (state == VPW_BRK)
                        | ((state == VPW_DATA) & lvl);
endmodule

/* vpw_tx_opcode_seq_tb.sv */
/*
 Self-checking bench of the VPW transmit opcode sequencer.
 Assumes the node model on the receive side and short symbol counts.
*/
`timescale 1ns/1ns
`include "vpw_consts.svh"
module vpw_tx_opcode_seq_tb;
    localparam logic [16:0] SOF = 17'h0A;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, busOutputPin, busIdle, eodMinPulse, rxCrcOk;
    logic        frameErr, bitErr, breakErr, rxIfrPortion, arbLost;
    logic        lastPin = 1'b0;
    logic [3:0]  rxByteCount;
    int          failures = 0;
    int          checked = 0;
    int          runLen = 0;
    int          runs[$];
    wire         hready = hreadyout;
    vpw_tx_opcode_seq #(.BRK_CYC(17'h14), .SOF_CYC(SOF), .SHORT_CYC(17'h4), .LONG_CYC(17'h8),
        .EOD_CYC(17'h0A)) vpw_tx_opcode_seq_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .busIdle(busIdle), .rxByteCount(rxByteCount), .eodMinPulse(eodMinPulse),
        .rxCrcOk(rxCrcOk), .frameErr(frameErr), .bitErr(bitErr), .breakErr(breakErr),
        .rxIfrPortion(rxIfrPortion), .arbLost(arbLost), .busOutputPin(busOutputPin));
    vpw_node_model vpw_node_model_inst (.clk(clk), .busOutputPin(busOutputPin),
        .busIdle(busIdle), .rxByteCount(rxByteCount), .eodMinPulse(eodMinPulse),
        .rxCrcOk(rxCrcOk), .frameErr(frameErr), .bitErr(bitErr), .breakErr(breakErr),
        .rxIfrPortion(rxIfrPortion), .arbLost(arbLost));
    initial forever #2 clk = ~clk;
    // ==========
    // Pin run lengths, one entry per level change
    always @(posedge clk) begin
        if (busOutputPin === lastPin) begin
            runLen++;
        end else begin
            runs.push_back(runLen);
            runLen = 1;
            lastPin = busOutputPin;
        end
    end
    // ==========
    // Reporting and bus cycles
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) begin
            failures++;
            wrap_up;
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        step;
        htrans <= 2'b00;
        hwdata <= d;
        step;
        rd = hrdata;
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        bus(1'b1, {20'h0, i, 2'b00}, {24'h0, d});
    endtask
    task automatic rdm(input string w, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, {20'h0, `VPW_IDX_STAT, 2'b00}, 32'h0);
        chk(w, rd & m, e);
    endtask
    // Polls a status bit; for bit 4 it then waits for an idle bus
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, {20'h0, `VPW_IDX_STAT, 2'b00}, 32'h0);
            n++;
        end while (rd[b] !== v && n < 300);
        while (b == 4 && busIdle !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            failures++;
            wrap_up;
        end
    endtask
    // Symbol k passive when even counted from act0; long passive means one
    function automatic logic [31:0] dec(input int base, input bit act0);
        logic [7:0] b;
        for (int k = 0; k < 8; k++) b[7-k] = (runs[base+k] == 8) ^ act0 ^ k[0];
        return {24'h0, b};
    endfunction
    function automatic logic [31:0] crc(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
        return {24'h0, ~c};
    endfunction
    // ==========
    // Scenarios
    task automatic s_regs;
        rdm("status reset", 32'hFF, 32'h1);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'hF8);
        bus(1'b0, {20'h0, `VPW_IDX_TRANSMIT_OPCODE, 2'b00}, 32'h0);
        chk("opcode bit3", rd, 32'hF0);
        bus(1'b0, 32'h0001_03CC, 32'h0);
        chk("unmapped", rd, 32'h0);
        wr(`VPW_IDX_CTRL, 8'h01);
        wr(`VPW_IDX_PADDR, 8'h5A);
    endtask
    task automatic s_msg;
        wr(`VPW_IDX_TRANSMIT_BYTE_REG, 8'hA5);
        runs.delete();
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'hF2);
        rdm("ready cleared", 32'h1, 32'h0);
        poll(0, 1'b1);
        wr(`VPW_IDX_TRANSMIT_BYTE_REG, 8'h3C);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h03);
        poll(4, 1'b0);
        chk("status after", rd, 32'h1);
        chk("sof width", runs[1], 32'(SOF));
        chk("first byte", dec(2, 0), 32'hA5);
        chk("second byte", dec(10, 0), 32'h3C);
        chk("crc byte", dec(18, 0), crc(16'hA53C));
        chk("symbol count", 32'(runs.size()), 32'h1A);
    endtask
    task automatic s_break;
        wr(`VPW_IDX_TRANSMIT_BYTE_REG, 8'h66);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h03);
        poll(0, 1'b1);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h01);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h00);
        chk("break held", {31'h0, busOutputPin}, 32'h1);
        poll(4, 1'b0);
        chk("cancel ready", rd, 32'h1);
    endtask
    task automatic s_len;
        for (int i = 0; i < 4; i++) begin
            wr(`VPW_IDX_TRANSMIT_OPCODE, {4'(12 + i), 1'b0, 3'(4 + i)});
            rdm("length abort", 32'hFF, 32'h3);
            wr(`VPW_IDX_STAT, 8'h00);
        end
        wr(`VPW_IDX_CTRL, 8'h03);
        runs.delete();
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'hD4);
        rdm("long count kept", 32'h3, 32'h0);
        vpw_node_model_inst.body_end(4'hD, 1'b1);
        poll(4, 1'b0);
        chk("address byte", dec(1, 1) & 32'hFE, 32'h5A);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h04);
        vpw_node_model_inst.body_end(4'h3, 1'b0);
        rdm("crc refused", 32'hE, 32'h8);
        wr(`VPW_IDX_STAT, 8'h00);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h54);
        vpw_node_model_inst.body_end(4'h6, 1'b1);
        rdm("count mismatch", 32'hE, 32'h2);
        wr(`VPW_IDX_STAT, 8'h00);
    endtask
    task automatic s_ulf;
        wr(`VPW_IDX_CTRL, 8'h01);
        vpw_node_model_inst.body_end(4'hA, 1'b1);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h02);
        rdm("message at ten", 32'h6, 32'h6);
        wr(`VPW_IDX_STAT, 8'h00);
        vpw_node_model_inst.body_end(4'hB, 1'b1);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h03);
        rdm("crc message at eleven", 32'h6, 32'h6);
        wr(`VPW_IDX_STAT, 8'h00);
        vpw_node_model_inst.body_end(4'h0, 1'b1);
        poll(4, 1'b0);
        runs.delete();
        wr(`VPW_IDX_TRANSMIT_BYTE_REG, 8'hC3);
        wr(`VPW_IDX_TRANSMIT_OPCODE, 8'h03);
        poll(0, 1'b1);
        poll(4, 1'b0);
        chk("new frame sof", runs[1], 32'(SOF));
        chk("new frame byte", dec(2, 0), 32'hC3);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        s_regs;
        s_msg;
        s_break;
        s_len;
        s_ulf;
        wrap_up;
    end
endmodule
bind vpw_tx_opcode_seq vpw_seq_chk #(.BRK_CYC(BRK_CYC), .SOF_CYC(SOF_CYC)) vpw_seq_chk_inst (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rxByteCount(rxByteCount), .busOutputPin(busOutputPin));
